// *** verif/scca_motor_model.sv ***
// Motor winding model: phase current samples and back-EMF zero crosses
module scca_motor_model
  import scca_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [8:0]  cur_level,
  input  wire logic        cur_strobe,
  input  wire logic [15:0] zc_period,
  output logic [8:0]       current_sample,
  output logic             current_valid,
  output logic             bemf_zero_cross
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] cnt;
  // Sample is only meaningful with its strobe; otherwise it keeps changing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt             <= 16'h0000;
      current_sample  <= 9'h000;
      current_valid   <= 1'b0;
      bemf_zero_cross <= 1'b0;
    end else begin
      current_valid <= cur_strobe;
      current_sample <= cur_strobe ? cur_level : ~current_sample;
      cnt <= (zc_period == 16'h0 || cnt == zc_period - 16'h1) ? 16'h0 : cnt + 16'h1;
      bemf_zero_cross <= zc_period != 16'h0 && cnt == zc_period - 16'h1;
    end
  end
endmodule

// *** verif/test_scca_speed_adv.sv ***
// Self-checking testbench of the speed-command and commutation-advance block
`include "scca_consts.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_scca_speed_adv
  import scca_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
  logic        speed_pin, current_valid, bemf_zero_cross, commutate, cur_strobe, pwm_on;
  logic [7:0]  paddr;
  logic [8:0]  speed_analog_code, current_sample, drive_amplitude, cur_level;
  logic [15:0] zc_period;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pwm_cnt;
  int          err_total, comparisons;

  scca_speed_adv #(.ACCEL_TICK_CYC(14'h2), .LEAD_UNIT_CYC(7'h64)) u_scca_speed_adv (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .speed_pin(speed_pin), .speed_analog_code(speed_analog_code),
    .current_sample(current_sample), .current_valid(current_valid),
    .bemf_zero_cross(bemf_zero_cross), .drive_amplitude(drive_amplitude),
    .commutate(commutate));
  scca_motor_model u_scca_motor_model (
    .pclk(pclk), .presetn(presetn), .cur_level(cur_level), .cur_strobe(cur_strobe),
    .zc_period(zc_period),
    .current_sample(current_sample), .current_valid(current_valid),
    .bemf_zero_cross(bemf_zero_cross));

  always #12.5 pclk = ~pclk;
  // Speed pin PWM: period 16 cycles, 50 % duty
  always @(posedge pclk) begin
    if (!presetn) begin
      pwm_cnt   <= 4'h0;
      speed_pin <= 1'b0;
    end else begin
      pwm_cnt <= pwm_cnt + 4'h1;
      if (pwm_on) begin
        speed_pin <= pwm_cnt[3];
      end
    end
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic timeout();
    err_total++;
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    print_verdict();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) timeout();
    rd = prdata;
    rd_err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic strobe(input logic [8:0] v);
    cur_level <= v;
    cur_strobe <= 1'b1;
    @(posedge pclk);
    cur_strobe <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_amp(input logic [8:0] v);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (drive_amplitude !== v && n < 3000);
    if (drive_amplitude !== v) timeout();
    @(posedge pclk);
  endtask

  task automatic t_reset();
    apb(1'b0, `SCCA_ADDR_CTRL, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b1, `SCCA_ADDR_STATUS, 32'hFFFF_FFFF);
    apb(1'b0, `SCCA_ADDR_STATUS, 32'h0);
    `CHK({rd_err, rd}, 33'h0_0000_0000)
    apb(1'b0, 8'h14, 32'h0);
    `CHK({rd_err, rd}, 33'h1_0000_0000)
  endtask
  task automatic t_reg_speed();
    logic [8:0] a0;
    apb(1'b1, `SCCA_ADDR_CTRL, 32'h39);
    apb(1'b1, `SCCA_ADDR_SPEED, 32'h1FF);
    apb(1'b0, `SCCA_ADDR_STATUS, 32'h0);
    `CHK(rd[24:16], 9'h1FF)
    a0 = drive_amplitude;
    cyc(40);
    `CHK(drive_amplitude - a0, 9'h014)
    wait_amp(9'h1FF);
    `CHK(drive_amplitude, 9'h1FF)
  endtask
  task automatic t_pin();
    logic [8:0] a0;
    speed_analog_code <= 9'h055;
    pwm_on <= 1'b1;
    cyc(9000);
    apb(1'b0, `SCCA_ADDR_STATUS, 32'h0);
    `CHK(rd[24:16], 9'h1FF)
    `CHK(drive_amplitude, 9'h1FF)
    apb(1'b1, `SCCA_ADDR_CTRL, 32'h3A);
    apb(1'b0, `SCCA_ADDR_STATUS, 32'h0);
    `CHK(rd[24:16], 9'h100)
    wait_amp(9'h100);
    `CHK(drive_amplitude, 9'h100)
    apb(1'b1, `SCCA_ADDR_CTRL, 32'h28);
    apb(1'b0, `SCCA_ADDR_STATUS, 32'h0);
    `CHK(rd[24:16], 9'h055)
    a0 = drive_amplitude;
    cyc(80);
    `CHK(a0 - drive_amplitude, 9'h00A)
  endtask
  task automatic t_lead0();
    logic [6:0]  code [5] = '{7'h00, 7'h01, 7'h28, 7'h69, 7'h7F};
    logic [17:0] lead [5] = '{18'h0, 18'h64, 18'hC80, 18'hE100, 18'h2EE00};
    foreach (code[i]) begin
      apb(1'b1, `SCCA_ADDR_CTRL, {17'h0, code[i], 8'h39});
      apb(1'b0, `SCCA_ADDR_LEAD, 32'h0);
      `CHK(rd[17:0], lead[i])
    end
    wait_amp(9'h1FF);
  endtask
  task automatic t_feedback();
    apb(1'b1, `SCCA_ADDR_CTRL, {17'h0, 7'h7F, 8'h79});
    strobe(9'h100);
    apb(1'b0, `SCCA_ADDR_FEEDBACK, 32'h0);
    `CHK({rd[24:16], rd[8:0]}, {9'h040, 9'h1BF})
    apb(1'b1, `SCCA_ADDR_CTRL, {17'h0, 7'h7F, 8'h39});
    strobe(9'h100);
    apb(1'b0, `SCCA_ADDR_FEEDBACK, 32'h0);
    `CHK({rd[24:16], rd[8:0]}, {9'h0A0, 9'h15F})
  endtask
  task automatic t_lead1();
    apb(1'b1, `SCCA_ADDR_CTRL, {17'h0, 7'h7F, 8'h3D});
    cyc(80);
    apb(1'b0, `SCCA_ADDR_LEAD, 32'h0);
    `CHK(rd[17:0], 18'hEAD5)
    repeat (12) strobe(9'h000);
    cyc(80);
    apb(1'b0, `SCCA_ADDR_LEAD, 32'h0);
    `CHK(rd[17:0], 18'h0)
  endtask
  task automatic t_comm();
    int n;
    int k;
    n = 0;
    k = 0;
    apb(1'b1, `SCCA_ADDR_CTRL, {17'h0, 7'h01, 8'h39});
    zc_period <= 16'd400;
    cyc(1000);
    while (bemf_zero_cross !== 1'b1 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 500) timeout();
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (commutate !== 1'b1 && n < 500);
    `CHK(n inside {[299:302]}, 1'b1)
    repeat (4000) begin
      @(posedge pclk);
      if (commutate === 1'b1) k++;
    end
    `CHK(k, 10)
    zc_period <= 16'h0;
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, cur_strobe, pwm_on} = 5'h00;
    {paddr, pwdata} = 40'h0000000000;
    {speed_analog_code, cur_level, zc_period} = 34'h0;
    err_total = 0;
    comparisons = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_reg_speed();
    t_pin();
    t_lead0();
    t_feedback();
    t_lead1();
    t_comm();
    print_verdict();
  end
endmodule

// *** verilog/scca_consts.svh ***
// Offsets, field positions, reset values and timing counts of the speed/advance block
`ifndef SCCA_CONSTS_SVH
`define SCCA_CONSTS_SVH

`define SCCA_ADDR_CTRL       8'h00
`define SCCA_ADDR_SPEED      8'h04
`define SCCA_ADDR_STATUS     8'h08
`define SCCA_ADDR_LEAD       8'h0C
`define SCCA_ADDR_FEEDBACK   8'h10

`define SCCA_CTRL_W          15
`define SCCA_CTRL_RESET      15'h0000
`define SCCA_SPEED_RESET     9'h000
`define SCCA_HI_FIELD_LSB    16

`define SCCA_SPEED_MAX       9'h1FF
`define SCCA_CLK_PERIOD_NS   25
`define SCCA_ADV_UNIT_NS     2500
`define SCCA_ADV_UNIT_CYC    ((`SCCA_ADV_UNIT_NS + `SCCA_CLK_PERIOD_NS - 1) / `SCCA_CLK_PERIOD_NS)
`define SCCA_ACCEL_TICK_CYC  64
`define SCCA_ACCEL_MAX_CODE  3'h7
`define SCCA_PWM_WIN_CYC     4096
`define SCCA_PWM_DUTY_SHIFT  3
`define SCCA_DIV_STEPS       5'h1B

`endif

// *** verilog/scca_lead_div.sv ***
// Sequential restoring divider for the variable commutation lead
`include "scca_consts.svh"
module scca_lead_div
  import scca_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          start,
  input  wire scca_div_req_t req,
  output logic               done,
  output logic [17:0]        quot
);

  scca_div_st_t st_ff;
  logic [26:0]  num_ff;
  logic [26:0]  q_ff;
  logic [9:0]   rem_ff;
  logic [8:0]   den_ff;
  logic [4:0]   step_ff;
  logic         done_ff;
  wire  [9:0]   shifted_w = {rem_ff[8:0], num_ff[26]};
  wire          fits_w = (shifted_w >= {1'b0, den_ff});
  wire  [9:0]   nxt_rem = fits_w ? (shifted_w - {1'b0, den_ff}) : shifted_w;
  wire          last_w = (step_ff == `SCCA_DIV_STEPS - 5'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff   <= DIV_IDLE;
      num_ff  <= 27'h0000000;
      q_ff    <= 27'h0000000;
      rem_ff  <= 10'h000;
      den_ff  <= 9'h000;
      step_ff <= 5'h00;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      unique case (st_ff)
        DIV_IDLE: begin
          if (start) begin
            st_ff   <= DIV_RUN;
            num_ff  <= req.num;
            den_ff  <= req.den;
            rem_ff  <= 10'h000;
            step_ff <= 5'h00;
          end
        end
        DIV_RUN: begin
          rem_ff  <= nxt_rem;
          num_ff  <= {num_ff[25:0], 1'b0};
          q_ff    <= {q_ff[25:0], fits_w};
          step_ff <= step_ff + 5'h01;
          if (last_w) begin
            st_ff   <= DIV_IDLE;
            done_ff <= 1'b1;
          end
        end
      endcase
    end
  end

  assign done = done_ff;
  assign quot = q_ff[17:0];

  sequence s_div_start;
    st_ff == DIV_IDLE && start;
  endsequence

  sequence s_div_done;
    ##28 done_ff;
  endsequence

  chk_div_latency : assert property (@(posedge pclk) disable iff (!presetn)
    s_div_start |-> s_div_done)
    else $error("Lead divider did not finish in 28 cycles");

endmodule

// *** verilog/scca_pkg.sv ***
// Types shared by the speed-command and commutation-advance block
package scca_pkg;

  typedef struct packed {
    logic [6:0] adv_code;
    logic [1:0] atten_coef;
    logic [2:0] accel_rate;
    logic       adv_mode;
    logic       in_type;
    logic       src_reg;
  } scca_cfg_t;

  typedef struct packed {
    logic [26:0] num;
    logic [8:0]  den;
  } scca_div_req_t;

  typedef enum logic {
    DIV_IDLE,
    DIV_RUN
  } scca_div_st_t;

endpackage

// *** verilog/scca_pwm_meter.sv ***
// Duty-cycle meter for the PWM-encoded speed pin
`include "scca_consts.svh"
module scca_pwm_meter
  import scca_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       pin_level,
  output logic [8:0]      duty
);

  logic [11:0] win_cnt_ff;
  logic [12:0] hi_cnt_ff;
  logic [8:0]  duty_ff;
  wire         win_end_w = (win_cnt_ff == 12'(`SCCA_PWM_WIN_CYC - 1));
  wire  [12:0] hi_next_w = hi_cnt_ff + {12'h000, pin_level};
  wire  [12:0] hi_scale_w = hi_next_w >> `SCCA_PWM_DUTY_SHIFT;
  wire  [8:0]  nxt_duty = (hi_scale_w > 13'(`SCCA_SPEED_MAX)) ? `SCCA_SPEED_MAX
                                                              : hi_scale_w[8:0];

  // High time over a fixed window, scaled to the 9-bit command range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt_ff <= 12'h000;
      hi_cnt_ff  <= 13'h0000;
      duty_ff    <= 9'h000;
    end else begin
      win_cnt_ff <= win_cnt_ff + 12'h001;
      hi_cnt_ff  <= win_end_w ? 13'h0000 : hi_next_w;
      if (win_end_w) begin
        duty_ff <= nxt_duty;
      end
    end
  end

  assign duty = duty_ff;

  chk_pwm_zero_duty : assert property (@(posedge pclk) disable iff (!presetn)
    win_end_w && hi_next_w == 13'h0000 |=> duty_ff == 9'h000)
    else $error("PWM duty not zero after an all-low window");

endmodule

// *** verilog/scca_speed_adv.sv ***
// Speed-command selection, rate limiting and commutation advance with an APB register file
`include "scca_consts.svh"
module scca_speed_adv
  import scca_pkg::*;
#(
  parameter logic [13:0] ACCEL_TICK_CYC = 14'(`SCCA_ACCEL_TICK_CYC),
  parameter logic [6:0]  LEAD_UNIT_CYC  = 7'(`SCCA_ADV_UNIT_CYC)
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        speed_pin,
  input  wire logic [8:0]  speed_analog_code,
  input  wire logic [8:0]  current_sample,
  input  wire logic        current_valid,
  input  wire logic        bemf_zero_cross,
  output logic [8:0]       drive_amplitude,
  output logic             commutate
);

  function automatic logic [8:0] sat_sub9(input logic [8:0] a, input logic [8:0] b);
    sat_sub9 = (a > b) ? (a - b) : 9'h000;
  endfunction

  // Base lead in clock cycles from the exponent/mantissa code
  function automatic logic [17:0] lead_base(input logic [6:0] code, input logic [6:0] unit);
    logic [10:0] scaled;
    scaled = {7'h00, code[3:0]} << code[6:4];
    lead_base = 18'(scaled) * 18'(unit);
  endfunction

  // Register file and APB slave
  scca_cfg_t   cfg_ff;
  logic [8:0]  speed_cmd_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] rd_mux_w;

  wire         apb_access_w = psel && penable;
  wire         apb_write_w  = apb_access_w && pwrite && pready_ff;
  wire         sel_ctrl_w   = (paddr == `SCCA_ADDR_CTRL);
  wire         sel_speed_w  = (paddr == `SCCA_ADDR_SPEED);
  wire         sel_stat_w   = (paddr == `SCCA_ADDR_STATUS);
  wire         sel_lead_w   = (paddr == `SCCA_ADDR_LEAD);
  wire         sel_fb_w     = (paddr == `SCCA_ADDR_FEEDBACK);
  wire         addr_hit_w   = sel_ctrl_w || sel_speed_w || sel_stat_w || sel_lead_w || sel_fb_w;
  wire         wr_ctrl_w    = apb_write_w && sel_ctrl_w;
  wire         wr_speed_w   = apb_write_w && sel_speed_w;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff       <= `SCCA_CTRL_RESET;
      speed_cmd_ff <= `SCCA_SPEED_RESET;
    end else begin
      if (wr_ctrl_w) begin
        cfg_ff <= pwdata[`SCCA_CTRL_W-1:0];
      end
      if (wr_speed_w) begin
        speed_cmd_ff <= pwdata[8:0];
      end
    end
  end

  // One wait state: data is registered in the first access cycle, answered in the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else begin
      pready_ff  <= apb_access_w && !pready_ff;
      pslverr_ff <= apb_access_w && !pready_ff && !addr_hit_w;
      if (apb_access_w && !pready_ff) begin
        prdata_ff <= rd_mux_w;
      end
    end
  end

  // Speed pin synchroniser, PWM meter and source selection
  logic pin_meta_ff;
  logic pin_sync_ff;
  logic [8:0] pwm_duty_w;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
    end else begin
      pin_meta_ff <= speed_pin;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  scca_pwm_meter u_pwm_meter (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_level (pin_sync_ff),
    .duty      (pwm_duty_w)
  );

  wire [8:0] pin_cmd_w = cfg_ff.in_type ? pwm_duty_w : speed_analog_code;
  wire [8:0] target_w  = cfg_ff.src_reg ? speed_cmd_ff : pin_cmd_w;

  // Rate limiter: one LSB per tick, tick interval set by the accel code
  logic [13:0] accel_cnt_ff;
  logic [8:0]  ramp_ff;
  wire  [2:0]  accel_shift_w = `SCCA_ACCEL_MAX_CODE - cfg_ff.accel_rate;
  wire  [13:0] accel_int_w   = ACCEL_TICK_CYC << accel_shift_w;
  wire         accel_tick_w  = (accel_cnt_ff >= accel_int_w - 14'h0001);
  wire  [8:0]  nxt_ramp      = (ramp_ff < target_w) ? ramp_ff + 9'h001 :
                               (ramp_ff > target_w) ? ramp_ff - 9'h001 : ramp_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accel_cnt_ff <= 14'h0000;
      ramp_ff      <= 9'h000;
    end else begin
      accel_cnt_ff <= accel_tick_w ? 14'h0000 : accel_cnt_ff + 14'h0001;
      if (accel_tick_w) begin
        ramp_ff <= nxt_ramp;
      end
    end
  end

  // The ramped code is the peak amplitude; 511 is full scale
  logic [8:0] amp_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_ff <= 9'h000;
    end else begin
      amp_ff <= ramp_ff;
    end
  end

  // Current feedback filter and back-EMF estimate
  logic [8:0] filt_ff;
  wire signed [9:0] fb_diff_w  = $signed({1'b0, current_sample}) - $signed({1'b0, filt_ff});
  wire signed [9:0] fb_step_w  = fb_diff_w >>> ({1'b0, cfg_ff.atten_coef} + 3'h1);
  wire        [8:0] nxt_filt   = 9'($signed({1'b0, filt_ff}) + fb_step_w);
  wire        [8:0] bemf_w     = sat_sub9(amp_ff, filt_ff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_ff <= 9'h000;
    end else if (current_valid) begin
      filt_ff <= nxt_filt;
    end
  end

  // Commutation lead
  logic [17:0]   lead_ff;
  logic [17:0]   div_quot_w;
  logic          div_done_w;
  logic          div_start_ff;
  logic [17:0]   lead_var_ff;
  wire  [17:0]   base_w     = lead_base(cfg_ff.adv_code, LEAD_UNIT_CYC);
  wire  [8:0]    headroom_w = sat_sub9(amp_ff, bemf_w);
  wire           clamp_w    = (bemf_w >= amp_ff);
  scca_div_req_t div_req_w;

  assign div_req_w.num = 27'(base_w) * 27'(headroom_w);
  assign div_req_w.den = amp_ff;

  scca_lead_div u_lead_div (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (div_start_ff),
    .req     (div_req_w),
    .done    (div_done_w),
    .quot    (div_quot_w)
  );

  wire [17:0] nxt_lead = !cfg_ff.adv_mode ? base_w :
                         clamp_w          ? 18'h00000 : lead_var_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_start_ff <= 1'b1;
      lead_var_ff  <= 18'h00000;
      lead_ff      <= 18'h00000;
    end else begin
      div_start_ff <= div_done_w;
      if (div_done_w) begin
        lead_var_ff <= div_quot_w;
      end
      lead_ff <= nxt_lead;
    end
  end

  // Commutation scheduler: fire lead cycles before the predicted zero cross
  logic [19:0] period_cnt_ff;
  logic [19:0] last_period_ff;
  logic        fired_ff;
  logic        commutate_ff;
  wire  [19:0] lead20_w  = {2'b00, lead_ff};
  wire  [19:0] fire_at_w = (lead20_w >= last_period_ff) ? 20'h00000 : last_period_ff - lead20_w;
  wire         fire_w    = !fired_ff && !bemf_zero_cross && (last_period_ff != 20'h00000) &&
                           (period_cnt_ff == fire_at_w);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_cnt_ff  <= 20'h00000;
      last_period_ff <= 20'h00000;
      fired_ff       <= 1'b0;
      commutate_ff   <= 1'b0;
    end else begin
      commutate_ff <= fire_w;
      if (bemf_zero_cross) begin
        last_period_ff <= period_cnt_ff;
        period_cnt_ff  <= 20'h00000;
        fired_ff       <= 1'b0;
      end else begin
        if (period_cnt_ff != 20'hFFFFF) begin
          period_cnt_ff <= period_cnt_ff + 20'h00001;
        end
        if (fire_w) begin
          fired_ff <= 1'b1;
        end
      end
    end
  end

  // Read-back multiplexer
  wire [31:0] rd_ctrl_w = {17'h00000, cfg_ff};
  wire [31:0] rd_spd_w  = {23'h000000, speed_cmd_ff};
  wire [31:0] rd_stat_w = {7'h00, target_w, 7'h00, amp_ff};
  wire [31:0] rd_lead_w = {14'h0000, lead_ff};
  wire [31:0] rd_fb_w   = {7'h00, filt_ff, 7'h00, bemf_w};
  assign rd_mux_w = sel_ctrl_w  ? rd_ctrl_w :
                    sel_speed_w ? rd_spd_w  :
                    sel_stat_w  ? rd_stat_w :
                    sel_lead_w  ? rd_lead_w :
                    sel_fb_w    ? rd_fb_w   : 32'h00000000;

  assign prdata          = prdata_ff;
  assign pready          = pready_ff;
  assign pslverr         = pslverr_ff;
  assign drive_amplitude = amp_ff;
  assign commutate       = commutate_ff;

  chk_pin_ignored : assert property (@(posedge pclk) disable iff (!presetn)
    cfg_ff.src_reg && !wr_ctrl_w && !wr_speed_w |=> $stable(target_w))
    else $error("Speed target moved while register source selected");

  chk_source_select : assert property (@(posedge pclk) disable iff (!presetn)
    wr_speed_w && cfg_ff.src_reg && !wr_ctrl_w |=> target_w == $past(pwdata[8:0]))
    else $error("Register command not taken as target");

  chk_ramp_step : assert property (@(posedge pclk) disable iff (!presetn)
    $changed(ramp_ff) |-> $past(accel_tick_w) &&
      (ramp_ff == $past(ramp_ff) + 9'h001 || ramp_ff == $past(ramp_ff) - 9'h001))
    else $error("Speed command changed faster than allowed");

  chk_amp_follows : assert property (@(posedge pclk) disable iff (!presetn)
    accel_tick_w && ramp_ff != target_w |-> ##2 amp_ff != $past(amp_ff))
    else $error("Drive amplitude did not follow the ramped command");

  chk_filter_hold : assert property (@(posedge pclk) disable iff (!presetn)
    !current_valid |=> $stable(filt_ff))
    else $error("Feedback filter changed without a current sample");

  chk_lead_fixed : assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_ff.adv_mode |=> lead_ff == $past(base_w))
    else $error("Fixed lead differs from base time");

  chk_lead_clamp : assert property (@(posedge pclk) disable iff (!presetn)
    cfg_ff.adv_mode && bemf_w >= amp_ff |=> lead_ff == 18'h00000)
    else $error("Variable lead not clamped to zero");

  chk_commutate_time : assert property (@(posedge pclk) disable iff (!presetn)
    commutate_ff |-> $past(period_cnt_ff) == $past(fire_at_w) && !$past(fired_ff))
    else $error("Commutation issued at the wrong time");

  sequence s_apb_take;
    apb_access_w && !pready_ff;
  endsequence

  sequence s_apb_answer;
    pready_ff ##1 !pready_ff;
  endsequence

  chk_apb_answer : assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_take |=> s_apb_answer)
    else $error("APB answer not one cycle after access");

  chk_apb_error : assert property (@(posedge pclk) disable iff (!presetn)
    apb_access_w && !pready_ff && !addr_hit_w |=> pslverr_ff && pready_ff)
    else $error("Unmapped address not answered with an error");

  chk_apb_err_pair : assert property (@(posedge pclk) disable iff (!presetn)
    pslverr_ff |-> pready_ff)
    else $error("Error flag outside the answer cycle");

  chk_read_data : assert property (@(posedge pclk) disable iff (!presetn)
    apb_access_w && !pready_ff && !pwrite |=> prdata_ff == $past(rd_mux_w))
    else $error("Read data not taken from the addressed register");

  chk_ctrl_write : assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl_w |=> cfg_ff == $past(pwdata[`SCCA_CTRL_W-1:0]))
    else $error("Control write not stored");

  chk_ramp_hold : assert property (@(posedge pclk) disable iff (!presetn)
    !accel_tick_w |=> $stable(ramp_ff))
    else $error("Speed command moved between accel ticks");

  chk_ramp_toward : assert property (@(posedge pclk) disable iff (!presetn)
    accel_tick_w && ramp_ff < target_w |=> ramp_ff == $past(ramp_ff) + 9'h001)
    else $error("Speed command did not step up toward its target");

  chk_lead_capture : assert property (@(posedge pclk) disable iff (!presetn)
    div_done_w |=> lead_var_ff == $past(div_quot_w))
    else $error("Divider result not captured");

  chk_lead_var : assert property (@(posedge pclk) disable iff (!presetn)
    cfg_ff.adv_mode && !clamp_w |=> lead_ff == $past(lead_var_ff))
    else $error("Variable lead differs from divider result");

  chk_commutate_once : assert property (@(posedge pclk) disable iff (!presetn)
    commutate_ff |=> !commutate_ff)
    else $error("Commutation pulse longer than one cycle");

endmodule
